// >>> logic/pmcs_pkg.sv
`default_nettype none
package pmcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int CORE_START_NS = 2000;
  localparam int STABILIZE_NS = 1000;

  // Least times round up to whole cycles, never below one
  function automatic int pmcs_cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CORE_START_CYC = pmcs_cyc_up(CORE_START_NS);
  localparam int STABILIZE_CYC = pmcs_cyc_up(STABILIZE_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQC = 8'h0C;
  localparam logic [7:0] OFS_IRQE = 8'h10;
  localparam int IRQC_GIE_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator control word, bit 7 down to bit 0
  typedef struct packed {
    logic idle_select_bit;
    logic [2:0] internal_freq_select;
    logic internal_source_select;
    logic rsvd;
    logic [1:0] clock_select_field;
  } pmcs_ctrl_t;
  localparam pmcs_ctrl_t CTRL_RST = 8'h00;

  // Start-up options, bit 2 down to bit 0
  typedef struct packed {
    logic two_speed_en;
    logic fail_safe_en;
    logic watchdog_en;
  } pmcs_cfg_t;
  localparam pmcs_cfg_t CFG_RST = 3'h0;

  typedef enum logic [6:0] {
    ST_RST_HOLD = 7'h01,
    ST_RUN_PRI = 7'h02,
    ST_RUN_INT = 7'h04,
    ST_IDLE_INT = 7'h08,
    ST_IDLE_PRI = 7'h10,
    ST_SLEEP = 7'h20,
    ST_WAKE = 7'h40
  } pmcs_state_t;

  // Status word, bit 14 down to bit 0
  typedef struct packed {
    pmcs_state_t mode;
    logic [3:0] rsvd;
    logic core_run;
    logic primary_on;
    logic startup_timer_done_flag;
    logic internal_osc_stable_flag;
  } pmcs_stat_t;

  // Clock enables towards the clock tree
  typedef struct packed {
    logic core;
    logic periph;
    logic internal_osc_mux;
    logic internal_osc;
    logic primary_osc;
    logic low_freq_rc_source;
  } pmcs_clken_t;

endpackage
`default_nettype wire

// >>> logic/pmcs_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pmcs_delay_timer
#(
  parameter int CYCLES = 1,
  parameter int CNT_W = 16
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic done_out
);

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
  logic [CNT_W-1:0] cnt_q;

  // Done pulses exactly CYCLES edges after the start edge
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || abort_in)
    begin
      cnt_q <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (start_in)
    begin
      cnt_q <= LOAD;
      busy_out <= 1'b1;
      done_out <= 1'b0;
    end
    else
    begin
      cnt_q <= (busy_out && cnt_q != 1) ? cnt_q - 1'b1 : cnt_q;
      busy_out <= busy_out && cnt_q != 1;
      done_out <= busy_out && cnt_q == 1;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pmcs_sequencer.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pmcs_sequencer
  import pmcs_pkg::*;
#(
  parameter int IRQ_W = 8,
  parameter int CORE_CYC = CORE_START_CYC,
  parameter int STAB_CYC = STABILIZE_CYC,
  parameter int CNT_W = 16
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sleep_instr_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic wdt_timeout_in,
  input wire logic [IRQ_W-1:0] irq_flags_in,
  input wire logic reset_source_in,
  input wire logic ost_ready_in,
  input wire logic clock_loss_in,
  output pmcs_clken_t clk_en_out,
  output logic [2:0] internal_freq_out,
  output logic wdt_clear_out,
  output logic wdt_reset_out,
  output logic irq_vector_out,
  output logic resume_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  pmcs_state_t state_q, state_d;
  pmcs_ctrl_t ctrl_q;
  pmcs_cfg_t cfg_q;
  pmcs_stat_t stat_w;
  logic irqc_q;
  logic [IRQ_W-1:0] irqe_q;
  logic internal_osc_stable_flag_q, startup_timer_done_flag_q, prim_en_q, osc_en_q, branch_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire run_w = state_q == ST_RUN_PRI || state_q == ST_RUN_INT;
  wire pm_w = state_q == ST_IDLE_INT || state_q == ST_IDLE_PRI || state_q == ST_SLEEP;
  wire upper_sel_w = ctrl_q.clock_select_field[1]; // Lower bit never read
  wire osc_en_w = ctrl_q.internal_freq_select != 3'h0 || ctrl_q.internal_source_select;
  wire early_ok_w = cfg_q.two_speed_en || cfg_q.fail_safe_en;

  // Wake only from enabled flags, the watchdog or reset
  wire irq_pend_w = |(irq_flags_in & irqe_q);
  wire wake_w = pm_w && (irq_pend_w || wdt_timeout_in) && !reset_source_in;
  wire wdt_run_rst_w = run_w && wdt_timeout_in;
  wire sleep_go_w = run_w && sleep_instr_in && !reset_source_in && !wdt_timeout_in;

  // Idle on the internal mux from internal run, or with upper select set
  wire pm_int_w = upper_sel_w || state_q == ST_RUN_INT;
  wire pmcs_state_t sleep_tgt_w = !ctrl_q.idle_select_bit ? ST_SLEEP :
                                  pm_int_w ? ST_IDLE_INT : ST_IDLE_PRI;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers
  wire stab_start_w = osc_en_w && !osc_en_q;
  logic stab_done_w, core_done_w;

  pmcs_delay_timer #(
    .CYCLES(STAB_CYC),
    .CNT_W(CNT_W)
  ) u_stab_timer (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .start_in(stab_start_w),
    .abort_in(!osc_en_w),
    .busy_out(),
    .done_out(stab_done_w)
  );

  pmcs_delay_timer #(
    .CYCLES(CORE_CYC),
    .CNT_W(CNT_W)
  ) u_core_timer (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .start_in(wake_w),
    .abort_in(reset_source_in),
    .busy_out(),
    .done_out(core_done_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing; a reset source or a run-mode time-out overrides all
  always_comb
  begin
    state_d = state_q;
    if (reset_source_in || wdt_run_rst_w)
      state_d = ST_RST_HOLD;
    else
    begin
      case (state_q)
        ST_RST_HOLD:
        begin
          if (upper_sel_w || (early_ok_w && !ost_ready_in))
            state_d = ST_RUN_INT;
          else if (ost_ready_in)
            state_d = ST_RUN_PRI;
        end
        ST_RUN_PRI:
        begin
          if (sleep_instr_in)
            state_d = sleep_tgt_w;
          else if (upper_sel_w)
            state_d = ST_RUN_INT;
        end
        ST_RUN_INT:
        begin
          if (sleep_instr_in)
            state_d = sleep_tgt_w;
          else if (prim_en_q && ost_ready_in && !upper_sel_w)
            state_d = ST_RUN_PRI;
        end
        ST_IDLE_INT, ST_IDLE_PRI, ST_SLEEP:
        begin
          if (wake_w)
            state_d = ST_WAKE;
        end
        ST_WAKE:
        begin
          if (core_done_w)
            state_d = (prim_en_q && ost_ready_in && !upper_sel_w) ? ST_RUN_PRI : ST_RUN_INT;
        end
        default:
          state_d = ST_RST_HOLD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator ownership; a shutdown wins over a restart request
  wire prim_off_w = state_d == ST_IDLE_INT || state_d == ST_SLEEP ||
                    (state_d == ST_RUN_INT && upper_sel_w);
  wire prim_on_w = state_d == ST_RST_HOLD ||
                   (state_q == ST_RUN_INT && !upper_sel_w && !sleep_go_w);
  wire enter_pri_w = state_d == ST_RUN_PRI && state_q != ST_RUN_PRI;
  wire reset_int_w = state_q == ST_RST_HOLD && state_d == ST_RUN_INT;
  wire leave_wake_w = state_q == ST_WAKE && state_d != ST_WAKE && state_d != ST_RST_HOLD;

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_RST_HOLD;
      prim_en_q <= 1'b1;
      startup_timer_done_flag_q <= 1'b0;
      osc_en_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      prim_en_q <= prim_off_w ? 1'b0 : (prim_on_w ? 1'b1 : prim_en_q);
      startup_timer_done_flag_q <= prim_off_w ? 1'b0 : (enter_pri_w ? 1'b1 : startup_timer_done_flag_q);
      osc_en_q <= osc_en_w;
    end
  end

  // Stable flag: cleared with the oscillator off, kept when already stable
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || !osc_en_w)
      internal_osc_stable_flag_q <= 1'b0;
    else if (stab_done_w || (reset_int_w && !stab_start_w))
      internal_osc_stable_flag_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and exit pulses
  wire ctrl_wr_w;
  wire freq_chg_w = ctrl_wr_w && s_axi_wdata_in[6:4] != ctrl_q.internal_freq_select;
  wire int_clk_w = state_q == ST_RUN_INT || state_q == ST_IDLE_INT || state_q == ST_WAKE;

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      wdt_clear_out <= 1'b0;
      wdt_reset_out <= 1'b0;
      irq_vector_out <= 1'b0;
      resume_out <= 1'b0;
      branch_q <= 1'b0;
    end
    else
    begin
      wdt_clear_out <= sleep_go_w || watchdog_clear_instr_in ||
                       (clock_loss_in && cfg_q.fail_safe_en) ||
                       (freq_chg_w && int_clk_w);
      wdt_reset_out <= wdt_run_rst_w && !reset_source_in;
      branch_q <= wake_w ? irq_pend_w && irqc_q : branch_q;
      irq_vector_out <= leave_wake_w && branch_q;
      resume_out <= leave_wake_w && !branch_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables; peripherals run in every mode except sleep and reset hold
  assign clk_en_out.core = run_w;
  assign clk_en_out.periph = state_q != ST_SLEEP && state_q != ST_RST_HOLD;
  assign clk_en_out.internal_osc_mux = int_clk_w;
  assign clk_en_out.internal_osc = osc_en_w;
  assign clk_en_out.primary_osc = prim_en_q && state_q != ST_SLEEP;
  assign clk_en_out.low_freq_rc_source = cfg_q.watchdog_en || cfg_q.fail_safe_en;
  assign internal_freq_out = ctrl_q.internal_freq_select;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data are taken together, one at a time
  wire wr_take_w = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
  wire rd_take_w = s_axi_arvalid_in && !rvalid_q;
  wire [7:0] wofs_w = 8'(s_axi_awaddr_in);
  wire [7:0] rofs_w = 8'(s_axi_araddr_in);
  wire wlane_w = wr_take_w && s_axi_wstrb_in[0];
  assign ctrl_wr_w = wlane_w && wofs_w == OFS_CTRL;
  wire w_hit_w = wofs_w == OFS_CTRL || wofs_w == OFS_CFG || wofs_w == OFS_STAT ||
                 wofs_w == OFS_IRQC || wofs_w == OFS_IRQE;
  wire r_hit_w = rofs_w == OFS_CTRL || rofs_w == OFS_CFG || rofs_w == OFS_STAT ||
                 rofs_w == OFS_IRQC || rofs_w == OFS_IRQE;

  assign stat_w = {state_q, 4'h0, run_w, prim_en_q, startup_timer_done_flag_q, internal_osc_stable_flag_q};
  wire [31:0] rd_mux_w =
    rofs_w == OFS_CTRL ? {24'h0, ctrl_q} :
    rofs_w == OFS_CFG ? {29'h0, cfg_q} :
    rofs_w == OFS_STAT ? {17'h0, stat_w} :
    rofs_w == OFS_IRQC ? 32'(irqc_q) << IRQC_GIE_BIT :
    rofs_w == OFS_IRQE ? 32'(irqe_q) : 32'h0;

  assign s_axi_awready_out = wr_take_w;
  assign s_axi_wready_out = wr_take_w;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

  // Writable registers; the sequencer itself never touches the select bits
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctrl_q <= CTRL_RST;
      cfg_q <= CFG_RST;
      irqc_q <= 1'b0;
      irqe_q <= '0;
    end
    else if (wlane_w)
    begin
      ctrl_q <= wofs_w == OFS_CTRL ? pmcs_ctrl_t'(s_axi_wdata_in[7:0]) : ctrl_q;
      cfg_q <= wofs_w == OFS_CFG ? pmcs_cfg_t'(s_axi_wdata_in[2:0]) : cfg_q;
      irqc_q <= wofs_w == OFS_IRQC ? s_axi_wdata_in[IRQC_GIE_BIT] : irqc_q;
      irqe_q <= wofs_w == OFS_IRQE ? s_axi_wdata_in[IRQ_W-1:0] : irqe_q;
    end
  end

  // Responses stand until the master takes them
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else
    begin
      bvalid_q <= wr_take_w || (bvalid_q && !s_axi_bready_in);
      bresp_q <= wr_take_w ? (w_hit_w ? RESP_OKAY : RESP_SLVERR) : bresp_q;
      rvalid_q <= rd_take_w || (rvalid_q && !s_axi_rready_in);
      rresp_q <= rd_take_w ? (r_hit_w ? RESP_OKAY : RESP_SLVERR) : rresp_q;
      rdata_q <= rd_take_w ? rd_mux_w : rdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  localparam int A_CORE_MAX = CORE_CYC + 2;

  sequence s_wake;
    wake_w && state_q != ST_WAKE;
  endsequence

  sequence s_idle_sleep;
    state_q == ST_RUN_INT && sleep_go_w && ctrl_q.idle_select_bit;
  endsequence

  a_idle_core_off: assert property (
    state_q == ST_IDLE_INT |-> !clk_en_out.core && clk_en_out.periph &&
      clk_en_out.internal_osc_mux)
    else $error("core clocked or peripherals stopped in internal idle");

  a_idle_entry: assert property (
    s_idle_sleep |=> state_q == ST_IDLE_INT && !clk_en_out.core)
    else $error("sleep with idle select did not enter internal idle");

  a_primary_stop: assert property (
    state_q == ST_IDLE_INT |-> !clk_en_out.primary_osc && !startup_timer_done_flag_q)
    else $error("primary still on or start-up flag set in internal idle");

  a_stab_wait: assert property (
    $rose(osc_en_w) && !reset_int_w |=> !internal_osc_stable_flag_q ##1 !internal_osc_stable_flag_q)
    else $error("stable flag set before stabilization time");

  a_stable_kept: assert property (
    internal_osc_stable_flag_q && sleep_go_w && $stable(ctrl_q) |=> internal_osc_stable_flag_q)
    else $error("stable flag lost across sleep");

  a_osc_off: assert property (
    !osc_en_w ##1 !osc_en_w |-> !internal_osc_stable_flag_q && !clk_en_out.internal_osc)
    else $error("oscillator or stable flag active with selects clear");

  a_wake_delay: assert property (
    s_wake |=> (!clk_en_out.core && clk_en_out.periph) ##[1:A_CORE_MAX]
      (irq_vector_out || resume_out || reset_source_in))
    else $error("core start delay not honoured on wake");

  a_wdt_run: assert property (
    run_w && wdt_timeout_in && !reset_source_in |=> wdt_reset_out &&
      state_q == ST_RST_HOLD)
    else $error("run-mode time-out did not reset");

  a_wdt_clear: assert property (
    sleep_go_w || watchdog_clear_instr_in |=> wdt_clear_out)
    else $error("watchdog not cleared");

  a_no_spurious: assert property (
    pm_w && !irq_pend_w && !wdt_timeout_in && !reset_source_in |=> pm_w)
    else $error("left power-managed mode without a trigger");

endmodule
`default_nettype wire

// >>> verification/pmcs_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pmcs_sequencer_bench
  import pmcs_pkg::*;
;
  localparam int CC = 3;
  localparam int SC = 4;
  logic clk_sys_in;
  logic reset_in = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] irq = 8'h00;
  logic rsrc = 1'h1;
  logic oscillator_startup_timer = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, wclr, wrst, vec, res;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] freq;
  pmcs_clken_t clk_en;
  wire [4:0] pls = {vec | res, wclr, wrst, vec, res};
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hABA3;

  ////////////////////////////////////////////////////////////////////////////
  // Only the low byte lane carries register data, so strobes stay all-on
  pmcs_sequencer #(.CORE_CYC(CC), .STAB_CYC(SC)) i_dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .sleep_instr_in(ev[0]),
    .watchdog_clear_instr_in(ev[1]), .wdt_timeout_in(ev[2]), .irq_flags_in(irq),
    .reset_source_in(rsrc), .ost_ready_in(oscillator_startup_timer), .clock_loss_in(ev[3]),
    .clk_en_out(clk_en), .internal_freq_out(freq), .wdt_clear_out(wclr),
    .wdt_reset_out(wrst), .irq_vector_out(vec), .resume_out(res)
  );

  // Free-running system clock
  initial
  begin
    clk_sys_in = 1'h0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Idle internal mode: core off, peripherals on the internal mux, primary off
  function automatic pmcs_clken_t exp_idle(input pmcs_ctrl_t c, input pmcs_cfg_t g);
    return {3'h3, (c.internal_freq_select != 3'h0) | c.internal_source_select, 1'h0,
      g.watchdog_en | g.fail_safe_en};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ready is looked at on the falling edge, where it equals its value at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(negedge clk_sys_in); while (awready !== 1'h1);
    @(posedge clk_sys_in);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(negedge clk_sys_in); while (bvalid !== 1'h1);
    chk(32'(bresp), 32'(er), "write response");
    @(posedge clk_sys_in);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk_sys_in); while (arready !== 1'h1);
    @(posedge clk_sys_in);
    arvalid <= 1'h0;
    do @(negedge clk_sys_in); while (rvalid !== 1'h1);
    d = rdata;
    chk(32'(rresp), 32'(er), "read response");
    @(posedge clk_sys_in);
    rready <= 1'h0;
  endtask

  // Ends any one-cycle event pulse, then counts edges until the chosen output pulses
  task automatic wp(input int b, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      ev <= 4'h0;
      @(negedge clk_sys_in);
      n++;
    end
    while (pls[b] !== 1'h1 && n < lim);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    int n;
    int k;
    int b;
    int clr0;
    pmcs_ctrl_t c;
    logic [2:0] f;
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    @(negedge clk_sys_in);
    chk(32'(clk_en), 32'h02, "enables after reset");
    @(posedge clk_sys_in);
    rsrc <= 1'h0;
    repeat (4) @(posedge clk_sys_in);
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RST_HOLD), "held for start-up timer");
    oscillator_startup_timer <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RUN_PRI), "primary run");
    chk(32'(d[1]), 32'h1, "start-up done");
    // Bus refusals at unmapped places; the read-only status word takes a write with OKAY and ignores it
    wr(8'h20, 32'h0, RESP_SLVERR);
    rd(8'h14, RESP_SLVERR, d);
    chk(d, 32'h0, "unmapped data");
    wr(OFS_STAT, 32'hFFFF, RESP_OKAY);
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RUN_PRI), "status not writable");
    // Watchdog and fail-safe options, all four combinations
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_CFG, 32'(k), RESP_OKAY);
      @(negedge clk_sys_in);
      chk(32'(clk_en.low_freq_rc_source), 32'(k != 0), "rc source");
    end
    // Clear instruction, then clock loss with the fail-safe monitor on
    for (k = 1; k < 4; k += 2)
    begin
      @(posedge clk_sys_in);
      ev <= 4'(1 << k);
      wp(3, 4, n);
      chk(32'(wclr), 32'h1, "watchdog clear");
    end
    // Oscillator enable by frequency field, then by source bit alone
    for (k = 0; k < 2; k++)
    begin
      f = 3'(rnd() % 7 + 1);
      c = (k == 1) ? 8'h08 : {1'h0, f, 4'h0};
      wr(OFS_CTRL, 32'(c), RESP_OKAY);
      @(negedge clk_sys_in);
      chk(32'(clk_en.internal_osc), 32'h1, "osc enabled");
      // Read taken at the last edge before the flag is due
      repeat (SC - 2) @(posedge clk_sys_in);
      rd(OFS_STAT, RESP_OKAY, d);
      chk(32'(d[0]), 32'h0, "stable too early");
      repeat (SC + 2) @(posedge clk_sys_in);
      rd(OFS_STAT, RESP_OKAY, d);
      chk(32'(d[0]), 32'h1, "stable flag");
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clk_sys_in);
      rd(OFS_STAT, RESP_OKAY, d);
      chk(32'(d[0]), 32'h0, "flag with osc off");
      chk(32'(clk_en.internal_osc), 32'h0, "osc off");
    end
    // Idle entry with the lower select bit set as well, oscillator already stable
    f = 3'(rnd() % 7 + 1);
    c = {1'h1, f, 4'h3};
    wr(OFS_CTRL, 32'(c) & 32'hF0, RESP_OKAY);
    wr(OFS_CTRL, 32'(c), RESP_OKAY);
    repeat (SC + 2) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    ev <= 4'h1;
    wp(3, 4, n);
    chk(32'(wclr), 32'h1, "clear on sleep");
    chk(32'(clk_en), 32'(exp_idle(c, 3'h3)), "idle enables");
    chk(32'(freq), 32'(f), "idle frequency");
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_IDLE_INT), "internal idle");
    chk(32'(d[0]), 32'h1, "flag kept");
    chk(32'(d[1]), 32'h0, "start-up done cleared");
    // A flag whose enable is off must not wake
    @(posedge clk_sys_in);
    irq <= 8'(rnd() | 32'h1);
    wp(4, 12, n);
    chk(32'(pls[4]), 32'h0, "disabled source woke");
    @(posedge clk_sys_in);
    irq <= 8'h00;
    // Interrupt wake with the global enable on, then off
    for (k = 1; k >= 0; k--)
    begin
      if (k == 0)
      begin
        @(posedge clk_sys_in);
        ev <= 4'h1;
        wp(3, 4, n);
      end
      b = int'(rnd() % 8);
      wr(OFS_IRQE, 32'(1 << b), RESP_OKAY);
      wr(OFS_IRQC, 32'(k << IRQC_GIE_BIT), RESP_OKAY);
      @(posedge clk_sys_in);
      irq <= 8'(1 << b);
      wp(4, 20, n);
      chk(32'(n), 32'(CC + 2), "wake delay");
      chk(32'(vec), 32'(k), "vector branch");
      chk(32'(res), 32'(k == 0), "plain resume");
      chk(32'({clk_en.core, clk_en.periph}), 32'h3, "clocks after wake");
      @(posedge clk_sys_in);
      irq <= 8'h00;
      rd(OFS_CTRL, RESP_OKAY, d);
      chk(d, 32'(c), "selects kept");
    end
    // Frequency change while the internal oscillator clocks the device
    clr0 = 0;
    c.internal_freq_select = 3'(c.internal_freq_select % 7 + 1);
    fork
      wr(OFS_CTRL, 32'(c), RESP_OKAY);
      repeat (5) @(negedge clk_sys_in) clr0 += int'(wclr === 1'h1);
    join
    chk(32'(clr0), 32'h1, "clear on frequency write");
    // Watchdog time-out: a wake from sleep, a reset from run
    c.idle_select_bit = 1'h0;
    wr(OFS_CTRL, 32'(c), RESP_OKAY);
    @(posedge clk_sys_in);
    ev <= 4'h1;
    wp(3, 4, n);
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_SLEEP), "sleep");
    @(posedge clk_sys_in);
    ev <= 4'h4;
    wp(4, 20, n);
    chk(32'({res, vec}), 32'h2, "timeout wake");
    @(posedge clk_sys_in);
    ev <= 4'h4;
    wp(2, 4, n);
    chk(32'(wrst), 32'h1, "timeout reset");
    // Upper select still set, so the restart lands on the internal clock
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RUN_INT), "internal restart");
    chk(32'(d[0]), 32'h1, "stable after restart");
    // Reset source in mid-run with the fail-safe monitor on and the primary not ready
    wr(OFS_CTRL, 32'h80, RESP_OKAY);
    oscillator_startup_timer <= 1'h0;
    rsrc <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    rsrc <= 1'h0;
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RUN_INT), "early start");
    chk(32'(d[2]), 32'h1, "primary kept starting");
    oscillator_startup_timer <= 1'h1;
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_RUN_PRI), "switch to primary");
    chk(32'(d[1]), 32'h1, "start-up done after switch");
    // Idle on the primary clock: core stops, peripherals and primary keep running
    @(posedge clk_sys_in);
    ev <= 4'h1;
    wp(3, 4, n);
    chk(32'({clk_en.core, clk_en.periph, clk_en.primary_osc}), 32'h3, "primary idle");
    rd(OFS_STAT, RESP_OKAY, d);
    chk(32'(d[14:8]), 32'(ST_IDLE_PRI), "idle on primary");
    summarize();
  end
endmodule
`default_nettype wire
